// ==== logic/smld_device.sv ====
// Purpose: driver end; serial shift register, latches, output drive codes
// Assumes: every link pin is asynchronous to CLOCK
// Notes:   link pins pass two flops; data and clock share one delay
//          a fall within three cycles of a frame rise may miss that load
//          outputs are drive codes only; levels are made off chip
//          row select is sampled every cycle; change it between frames
`timescale 1ns/1ps
module smld_device #(
    parameter int OSC_HALF = smld_pkg::FRAME_HALF_CYC
) (
    // clock and reset
    input  wire logic                                   CLOCK,
    input  wire logic                                   RST,
    // link
    smld_link_if.device                                 LINK,
    // configuration strap
    input  wire logic                                   ROW_SEL,
    // display side
    output logic [smld_pkg::NUM_OUT*smld_pkg::CODE_W-1:0] DRIVE,
    output logic [smld_pkg::NUM_OUT-1:0]                LATCH,
    output logic                                        ROW_MODE,
    output logic                                        FRAME_PHASE
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // pin synchronisers
        logic                                   sclk_s1;
        logic                                   sclk_s2;
        logic                                   sclk_p;
        logic                                   dat_s1;
        logic                                   dat_s2;
        logic                                   ce_s1;
        logic                                   ce_s2;
        logic                                   poe_s1;
        logic                                   poe_s2;
        logic                                   ph_s1;
        logic                                   ph_s2;
        logic                                   row_s1;
        logic                                   row_s2;

        // oscillator and frame request
        logic [smld_pkg::CNT_W-1:0]             osc_cnt;
        logic                                   osc_lvl;
        logic                                   frame;

        // row data and display
        logic [smld_pkg::NUM_OUT-1:0]           shreg;
        logic [smld_pkg::NUM_OUT-1:0]           latch;
        logic [smld_pkg::NUM_OUT*smld_pkg::CODE_W-1:0] drive;
        logic                                   row_mode;
    } smld_dev_st_t;

    smld_dev_st_t st_q;
    smld_dev_st_t st_d;

    // ------------------------------------------------------------
    // drive code of one output
    // ------------------------------------------------------------
    function automatic logic [1:0] drv_code(
        input logic set,
        input logic row,
        input logic phase
    );
        logic [1:0] c;
        c = smld_pkg::DRV_MID;
        if (row) begin
            if (set) begin
                if (phase) begin
                    c = smld_pkg::DRV_LOW;
                end else begin
                    c = smld_pkg::DRV_HIGH;
                end
            end else begin
                c = smld_pkg::DRV_MID;
            end
        end else begin
            if (set) begin
                if (phase) begin
                    c = smld_pkg::DRV_HIGH;
                end else begin
                    c = smld_pkg::DRV_LOW;
                end
            end else begin
                if (phase) begin
                    c = smld_pkg::DRV_LOW;
                end else begin
                    c = smld_pkg::DRV_HIGH;
                end
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // edge of a level seen through two samples
    // ------------------------------------------------------------
    function automatic logic is_edge(
        input logic prev_lvl,
        input logic cur_lvl,
        input logic rising
    );
        logic e;
        e = prev_lvl & ~cur_lvl;
        if (rising) begin
            e = cur_lvl & ~prev_lvl;
        end
        return e;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic sclk_fall;
    logic frame_rise;
    logic frame_src;

    always_comb begin
        st_d = st_q;

        // --------------------------------------------------------
        // synchronisers; stage one feeds stage two only
        // --------------------------------------------------------
        st_d.sclk_s1 = LINK.shift_clk;
        st_d.sclk_s2 = st_q.sclk_s1;
        st_d.sclk_p  = st_q.sclk_s2;
        st_d.dat_s1  = LINK.ser_data;
        st_d.dat_s2  = st_q.dat_s1;
        st_d.ce_s1   = LINK.clk_en;
        st_d.ce_s2   = st_q.ce_s1;
        st_d.poe_s1  = LINK.phase_oe;
        st_d.poe_s2  = st_q.poe_s1;
        st_d.ph_s1   = LINK.phase_o;
        st_d.ph_s2   = st_q.ph_s1;
        st_d.row_s1  = ROW_SEL;
        st_d.row_s2  = st_q.row_s1;

        // --------------------------------------------------------
        // falling shift clock, qualified by the enable
        // --------------------------------------------------------
        sclk_fall = is_edge(st_q.sclk_p, st_q.sclk_s2, 1'b0);

        if (sclk_fall && st_q.ce_s2) begin
            // first bit walks up to bit 31, which is output 32
            st_d.shreg = {st_q.shreg[smld_pkg::NUM_OUT-2:0], st_q.dat_s2};
        end

        // --------------------------------------------------------
        // free-running oscillator; equal halves by one shared count
        // --------------------------------------------------------
        if (st_q.osc_cnt >= smld_pkg::CNT_W'(OSC_HALF - 1)) begin
            st_d.osc_cnt = '0;
            st_d.osc_lvl = ~st_q.osc_lvl;
        end else begin
            st_d.osc_cnt = st_q.osc_cnt + smld_pkg::CNT_W'(1);
        end

        // --------------------------------------------------------
        // a driven pin wins over the oscillator
        // --------------------------------------------------------
        if (st_q.poe_s2) begin
            frame_src = st_q.ph_s2;
        end else begin
            frame_src = st_q.osc_lvl;
        end
        st_d.frame = frame_src;

        // --------------------------------------------------------
        // load in the same cycle the request rises
        // --------------------------------------------------------
        frame_rise = is_edge(st_q.frame, frame_src, 1'b1);
        if (frame_rise) begin
            st_d.latch = st_q.shreg;
        end

        // --------------------------------------------------------
        // mode latched with the drive so codes never mix modes
        // --------------------------------------------------------
        st_d.row_mode = st_q.row_s2;

        // --------------------------------------------------------
        // drive codes; this cycle's phase so codes never lag the request
        // --------------------------------------------------------
        for (int i = 0; i < smld_pkg::NUM_OUT; i++) begin
            // a set latch bit is a visible element
            st_d.drive[i*smld_pkg::CODE_W +: smld_pkg::CODE_W] =
                drv_code(st_d.latch[i], st_q.row_s2, frame_src);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs; every one is a flop of the state
    // ------------------------------------------------------------
    assign LINK.frame_req = st_q.frame;
    assign DRIVE          = st_q.drive;
    assign LATCH          = st_q.latch;
    assign ROW_MODE       = st_q.row_mode;
    assign FRAME_PHASE    = st_q.frame;

endmodule // smld_device

// ==== logic/smld_pkg.sv ====
// Purpose: shared constants for the serial matrix lcd driver link
// Assumes: CLOCK at 100 MHz on both ends
// Notes:   no registers; all control is by pins
package smld_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_OUT  = 32;
    localparam int CODE_W   = 2;
    localparam int ROW_W    = 5;
    localparam int CNT_W    = 32;

    // ------------------------------------------------------------
    // drive codes; in column mode LOW/HIGH mean the .32/.68 levels
    // ------------------------------------------------------------
    localparam logic [1:0] DRV_LOW  = 2'h0;
    localparam logic [1:0] DRV_HIGH = 2'h1;
    localparam logic [1:0] DRV_MID  = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int FRAME_HALF_US  = 500;
    localparam int FRAME_HALF_CYC = FRAME_HALF_US * CLK_MHZ;
    localparam int SCLK_HALF_NS   = 400;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage

// ==== logic/smld_link_if.sv ====
// Purpose: pins between host and driver
// Assumes: frame phase pin is driven only by the host
// Notes:   phase_oe low means the driver ignores the pin and oscillates
`timescale 1ns/1ps
interface smld_link_if;
    logic shift_clk;
    logic ser_data;
    logic clk_en;
    logic phase_o;
    logic phase_oe;
    logic frame_req;

    modport device (
        input  shift_clk,
        input  ser_data,
        input  clk_en,
        input  phase_o,
        input  phase_oe,
        output frame_req
    );

    modport host (
        output shift_clk,
        output ser_data,
        output clk_en,
        output phase_o,
        output phase_oe,
        input  frame_req
    );
endinterface

// ==== logic/smld_host.sv ====
// Purpose: host end; refresh loop that shifts one row per frame
// Assumes: user supplies the word for ROW_IDX on request
// Notes:   shifting starts only after a frame rise, once WORD_VALID is seen
`timescale 1ns/1ps
module smld_host #(
    parameter int PHASE_HALF = smld_pkg::FRAME_HALF_CYC
) (
    // clock and reset
    input  wire logic                         CLOCK,
    input  wire logic                         RST,
    // link
    smld_link_if.host                         LINK,
    // user side
    input  wire logic                         PHASE_DRIVE,
    input  wire logic                         WORD_VALID,
    input  wire logic [smld_pkg::NUM_OUT-1:0] WORD,
    output logic                              WORD_READY,
    output logic [smld_pkg::ROW_W-1:0]        ROW_IDX,
    output logic                              FRAME_SEEN
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_LOAD = 4'b0010,
        H_HIGH = 4'b0100,
        H_LOW  = 4'b1000
    } smld_host_fsm_t;

    typedef struct packed {
        smld_host_fsm_t                 fsm;
        logic                           fr_s1;
        logic                           fr_s2;
        logic                           fr_p;
        logic [smld_pkg::NUM_OUT-1:0]   word;
        logic [smld_pkg::ROW_W-1:0]     bitn;
        logic [smld_pkg::ROW_W-1:0]     row;
        logic [smld_pkg::CNT_W-1:0]     tick;
        logic [smld_pkg::CNT_W-1:0]     ph_cnt;
        logic                           ph_lvl;
        logic                           ph_oe;
        logic                           sclk;
        logic                           sdat;
        logic                           ce;
        logic                           ready;
        logic                           seen;
    } smld_host_st_t;

    smld_host_st_t st_q;
    smld_host_st_t st_d;

    logic frame_rise;
    logic tick_done;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.fr_s1 = LINK.frame_req;
        st_d.fr_s2 = st_q.fr_s1;
        st_d.fr_p  = st_q.fr_s2;
        frame_rise = st_q.fr_s2 & ~st_q.fr_p;
        st_d.seen  = frame_rise;
        tick_done  = st_q.tick >= smld_pkg::CNT_W'(smld_pkg::SCLK_HALF_CYC - 1);
        st_d.tick  = tick_done ? '0 : st_q.tick + smld_pkg::CNT_W'(1);

        // square wave with equal halves when the host owns the phase
        st_d.ph_oe = PHASE_DRIVE;
        if (st_q.ph_cnt >= smld_pkg::CNT_W'(PHASE_HALF - 1)) begin
            st_d.ph_cnt = '0;
            st_d.ph_lvl = ~st_q.ph_lvl;
        end else begin
            st_d.ph_cnt = st_q.ph_cnt + smld_pkg::CNT_W'(1);
        end

        // backplanes advance one per frame, in order
        if (frame_rise) begin
            st_d.row = st_q.row + smld_pkg::ROW_W'(1);
        end

        case (st_q.fsm)
            H_IDLE: begin
                if (frame_rise) begin
                    st_d.fsm   = H_LOAD;
                    st_d.ready = 1'b1;
                end
            end
            H_LOAD: begin
                if (WORD_VALID) begin
                    st_d.ready = 1'b0;
                    st_d.word  = WORD;
                    st_d.bitn  = '0;
                    st_d.tick  = '0;
                    st_d.ce    = 1'b1;
                    // msb first so it ends on output 32
                    st_d.sdat  = WORD[smld_pkg::NUM_OUT-1];
                    st_d.fsm   = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tick_done) begin
                    st_d.sclk = 1'b0;
                    st_d.fsm  = H_LOW;
                end
            end
            H_LOW: begin
                if (tick_done) begin
                    // data changes on the rise, far from the fall
                    st_d.sclk = 1'b1;
                    st_d.word = {st_q.word[smld_pkg::NUM_OUT-2:0], 1'b0};
                    st_d.sdat = st_q.word[smld_pkg::NUM_OUT-2];
                    if (st_q.bitn == smld_pkg::ROW_W'(smld_pkg::NUM_OUT - 1)) begin
                        st_d.ce  = 1'b0;
                        st_d.fsm = H_IDLE;
                    end else begin
                        st_d.bitn = st_q.bitn + smld_pkg::ROW_W'(1);
                        st_d.fsm  = H_HIGH;
                    end
                end
            end
            default: begin
                st_d.fsm = H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_q      <= '0;
            st_q.fsm  <= H_IDLE;
            st_q.sclk <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign LINK.shift_clk = st_q.sclk;
    assign LINK.ser_data  = st_q.sdat;
    assign LINK.clk_en    = st_q.ce;
    assign LINK.phase_o   = st_q.ph_lvl;
    assign LINK.phase_oe  = st_q.ph_oe;
    assign WORD_READY     = st_q.ready;
    assign ROW_IDX        = st_q.row;
    assign FRAME_SEEN     = st_q.seen;

endmodule // smld_host

// ==== verification/smld_link_chk.sv ====
// Purpose: assertions on the link between host and driver
// Assumes: HALF is the frame half period of both ends
// Notes:   sees link pins only; display outputs are left to the bench
`timescale 1ns/1ps
module smld_link_chk #(
    parameter int HALF = smld_pkg::FRAME_HALF_CYC
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // link
    input wire logic shift_clk,
    input wire logic ser_data,
    input wire logic clk_en,
    input wire logic phase_o,
    input wire logic phase_oe,
    input wire logic frame_req
);
    // ----------
    // helpers
    // ----------
    logic [15:0] run_q;
    logic [3:0]  age_q;
    logic [5:0]  falls_q;
    logic        clean_q;
    logic        fr_q;
    logic        oe_q;
    logic        sc_q;
    logic        edge_w;
    assign edge_w = frame_req != fr_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            run_q   <= '0;
            age_q   <= '0;
            falls_q <= '0;
            clean_q <= 1'b0;
            fr_q    <= 1'b0;
            oe_q    <= 1'b0;
            sc_q    <= 1'b1;
        end else begin
            fr_q    <= frame_req;
            oe_q    <= phase_oe;
            sc_q    <= shift_clk;
            run_q   <= edge_w ? 16'h0001 : run_q + 16'h0001;
            age_q   <= (phase_oe != oe_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
            // a half opened or crossed by a source switch is not a real half
            clean_q <= edge_w ? (age_q > 4'h8 && phase_oe == oe_q) : (clean_q && phase_oe == oe_q);
            falls_q <= !clk_en ? 6'h00 : falls_q + {5'h00, sc_q && !shift_clk};
        end
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_ph_up;
        phase_oe && $rose(phase_o);
    endsequence
    sequence s_ph_dn;
        phase_oe && $fell(phase_o);
    endsequence
    sequence s_fr_up;
        ##[2:4] ($rose(frame_req) || !phase_oe);
    endsequence
    sequence s_fr_dn;
        ##[2:4] ($fell(frame_req) || !phase_oe);
    endsequence
    chk_phase_rise: assert property (s_ph_up |-> s_fr_up)
        else $error("frame request missed a phase rise");
    chk_phase_fall: assert property (s_ph_dn |-> s_fr_dn)
        else $error("frame request missed a phase fall");
    chk_frame_halves: assert property (edge_w && clean_q && age_q > 4'h8 |-> int'(run_q) == HALF)
        else $error("frame request half period wrong");
    chk_burst_len: assert property ($fell(clk_en) |-> falls_q == 6'h20)
        else $error("row burst is not 32 falls");
    chk_data_move: assert property (clk_en && $past(clk_en) && $changed(ser_data) |-> $rose(shift_clk))
        else $error("serial data moved away from a clock rise");
    chk_fall_hold: assert property ($fell(shift_clk) |-> (!shift_clk && $stable(ser_data)) [*8])
        else $error("data or clock unsettled after a fall");
    chk_fall_enabled: assert property ($fell(shift_clk) |-> clk_en && !$rose(frame_req))
        else $error("shift fall outside an enabled burst");
    chk_rise_clear: assert property ($rose(frame_req) |-> (!$fell(shift_clk)) [*8])
        else $error("shift fall too close to a frame rise");
endmodule // smld_link_chk

// ==== verification/testbench.sv ====
// Purpose: end to end bench for host and driver over the link
// Assumes: both ends run 1500 cycle frame halves
// Notes:   a second driver on a bench-made link takes the odd cases
`timescale 1ns/1ps
module testbench;
    localparam int HALF = 1500;
    localparam int LIM  = 4 * HALF;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic        row_sel = 1'b1;
    logic        row_sel_b = 1'b0;
    logic        phase_drive = 1'b1;
    logic        word_valid = 1'b0;
    logic [31:0] word = 32'h0000_0000;
    logic [31:0] mon_q = 32'h0000_0000;
    logic [63:0] drive;
    logic [63:0] drive_b;
    logic [31:0] latch;
    logic [31:0] latch_b;
    logic        row_mode;
    logic        phase;
    logic        phase_b;
    logic        ready;
    logic        seen;
    logic [4:0]  row_idx;
    logic [4:0]  idx_exp;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_falls = 0;
    int          falls0;
    // rows: row select, phase drive, word
    logic [33:0] rows [4] = '{{2'b11, 32'h8000_0001}, {2'b01, 32'hA5C3_0F96},
                              {2'b00, 32'hFFFF_0000}, {2'b10, 32'h1234_5678}};
    smld_link_if link ();
    smld_link_if link_b ();
    always #5 CLOCK = ~CLOCK;
    smld_host #(.PHASE_HALF(HALF)) smld_host_inst (.CLOCK(CLOCK), .RST(RST), .LINK(link),
        .PHASE_DRIVE(phase_drive), .WORD_VALID(word_valid), .WORD(word), .WORD_READY(ready),
        .ROW_IDX(row_idx), .FRAME_SEEN(seen));
    smld_device #(.OSC_HALF(HALF)) smld_device_inst (.CLOCK(CLOCK), .RST(RST), .LINK(link),
        .ROW_SEL(row_sel), .DRIVE(drive), .LATCH(latch), .ROW_MODE(row_mode), .FRAME_PHASE(phase));
    smld_device #(.OSC_HALF(200)) smld_device_inst_b (.CLOCK(CLOCK), .RST(RST), .LINK(link_b),
        .ROW_SEL(row_sel_b), .DRIVE(drive_b), .LATCH(latch_b), .ROW_MODE(), .FRAME_PHASE(phase_b));
    smld_link_chk #(.HALF(HALF)) smld_link_chk_inst (.CLOCK(CLOCK), .RST(RST), .shift_clk(link.shift_clk),
        .ser_data(link.ser_data), .clk_en(link.clk_en), .phase_o(link.phase_o), .phase_oe(link.phase_oe),
        .frame_req(link.frame_req));
    // wire-side capture of every enabled fall
    always @(negedge link.shift_clk) begin
        if (link.clk_en === 1'b1) begin
            mon_q = {mon_q[30:0], link.ser_data};
            n_falls++;
        end
    end
    // ----------
    // tasks
    // ----------
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_for(ref logic s, input logic lvl, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge CLOCK);
            k++;
        end while (s !== lvl && k < lim);
        if (s !== lvl) begin
            n_errors++;
            $display("CHECK FAILED wait expected %b seen %b", lvl, s);
            report_and_stop();
        end
    endtask
    function automatic logic [63:0] exp_drive(input logic [31:0] w, input logic rm, input logic ph);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            if (rm) r[2*i +: 2] = w[i] ? (ph ? smld_pkg::DRV_LOW : smld_pkg::DRV_HIGH) : smld_pkg::DRV_MID;
            else r[2*i +: 2] = (w[i] == ph) ? smld_pkg::DRV_HIGH : smld_pkg::DRV_LOW;
        end
        return r;
    endfunction
    // link clock made here, 125 ns, only within bursts
    task automatic shift_b(input logic [31:0] v, input int n, input logic en);
        // gap so a second call never lands on the last rise of the first
        #62.5;
        for (int i = n - 1; i >= 0; i--) begin
            link_b.ser_data = v[i];
            link_b.clk_en = en;
            #62.5 link_b.shift_clk = 1'b0;
            #62.5 link_b.shift_clk = 1'b1;
        end
        link_b.clk_en = 1'b0;
        link_b.ser_data = ~link_b.ser_data;
    endtask
    task automatic pulse_b(input logic [31:0] w);
        @(negedge CLOCK);
        link_b.phase_o = 1'b1;
        wait_for(phase_b, 1'b1, 8);
        check("latch b", latch_b, w);
        check("drive b hi", drive_b, exp_drive(w, row_sel_b, 1'b1));
        link_b.phase_o = 1'b0;
        wait_for(phase_b, 1'b0, 8);
        check("drive b lo", drive_b, exp_drive(w, row_sel_b, 1'b0));
    endtask
    task automatic check_reset();
        check("reset drive", drive, exp_drive(32'h0000_0000, 1'b0, 1'b0));
        check("reset latch", {latch, latch_b}, 64'h0);
        check("reset state", {ready, phase, phase_b, row_idx, link.clk_en, link.shift_clk}, 64'h1);
    endtask
    // ----------
    // sequence
    // ----------
    initial begin
        link_b.shift_clk = 1'b1;
        link_b.ser_data = 1'b0;
        link_b.clk_en = 1'b0;
        link_b.phase_o = 1'b0;
        link_b.phase_oe = 1'b1;
        repeat (16) @(negedge CLOCK);
        RST = 1'b0;
        @(negedge CLOCK);
        check_reset();
        for (int r = 0; r < 4; r++) begin
            row_sel = rows[r][33];
            phase_drive = rows[r][32];
            // two frames let a phase source switch settle
            wait_for(seen, 1'b1, LIM);
            wait_for(seen, 1'b1, LIM);
            idx_exp = row_idx + 5'h01;
            word = rows[r][31:0];
            word_valid = 1'b1;
            wait_for(ready, 1'b0, 8);
            word_valid = 1'b0;
            falls0 = n_falls;
            wait_for(seen, 1'b1, LIM);
            check("row index", row_idx, idx_exp);
            check("wire bits", mon_q, word);
            check("fall count", n_falls - falls0, 32);
            check("link idle", {link.clk_en, link.shift_clk}, 2'b01);
            check("latch", latch, word);
            check("row mode", row_mode, rows[r][33]);
            check("drive hi", drive, exp_drive(word, rows[r][33], 1'b1));
            wait_for(phase, 1'b0, LIM);
            check("drive lo", drive, exp_drive(word, rows[r][33], 1'b0));
        end
        shift_b(32'hC0FF_EE01, 32, 1'b1);
        shift_b(32'h1234_5678, 32, 1'b0);
        pulse_b(32'hC0FF_EE01);
        row_sel_b = 1'b1;
        shift_b(32'h0000_000C, 4, 1'b1);
        pulse_b(32'h0FFE_E01C);
        // reset again in mid-burst
        wait_for(seen, 1'b1, LIM);
        word_valid = 1'b1;
        wait_for(ready, 1'b0, 8);
        word_valid = 1'b0;
        repeat (200) @(negedge CLOCK);
        RST = 1'b1;
        repeat (16) @(negedge CLOCK);
        RST = 1'b0;
        @(negedge CLOCK);
        check_reset();
        report_and_stop();
    end
endmodule // testbench
